// ==== common/pmu_regs.svh ====
// Purpose: register offsets, reset values and timing counts of the power manager
// Assumes: 100 MHz system clock, word-indexed register port
// Notes:   definitions only
`ifndef PMU_REGS_SVH
`define PMU_REGS_SVH

// ----------------------------------------------------------------
// register offsets (word index)
// ----------------------------------------------------------------
`define PMU_OFF_CTRL      4'h0
`define PMU_OFF_STATE     4'h1
`define PMU_OFF_DOZE      4'h2
`define PMU_OFF_STBY      4'h3
`define PMU_OFF_CPU_STALL_MODULATION      4'h4
`define PMU_OFF_HKEEP     4'h5
`define PMU_OFF_PERIPH    4'h6
`define PMU_OFF_STALL     4'h7
`define PMU_OFF_PLANES    4'h8
`define PMU_OFF_IRQ_STAT  4'h9
`define PMU_OFF_IRQ_MASK  4'hA

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMU_CTRL_REQ_LSB  0
`define PMU_CTRL_EN_BIT   2
`define PMU_EV_DOZE       0
`define PMU_EV_STBY       1
`define PMU_EV_CPU_STALL_MODULATION       2
`define PMU_EV_HKEEP      3
`define PMU_EV_PERIPH     4
`define PMU_EV_WAKE       5
`define PMU_EV_NUM        6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMU_RST_DOZE      32'h0000_0400
`define PMU_RST_STBY      32'h0001_0000
`define PMU_RST_CPU_STALL_MODULATION      32'h0010_0000
`define PMU_RST_HKEEP     32'h0000_0100
`define PMU_RST_PERIPH    32'h0004_0000
`define PMU_RST_STALL     8'h00
`define PMU_RST_PLANES    8'hFF
`define PMU_RST_MASK      6'h00

// ----------------------------------------------------------------
// timing: suspend handshake time-out, in ns and in cycles
// ----------------------------------------------------------------
`define PMU_CLK_NS        10
`define PMU_DRAIN_NS      2000
`define PMU_DRAIN_CYC     ((`PMU_DRAIN_NS + `PMU_CLK_NS - 1) / `PMU_CLK_NS)

`endif

// ==== common/pmu_pkg.sv ====
// Purpose: types shared by the power manager files
// Assumes: nothing
// Notes:   constants live in pmu_regs.svh
`default_nettype none
package pmu_pkg;

    typedef enum logic [1:0] {
        PMU_ON,
        PMU_DOZE,
        PMU_STBY,
        PMU_CPU_STALL_MODULATION
    } pmu_pstate_type;

    typedef struct packed {
        logic       sys;
        logic       hkeep;
        logic       periph;
    } pmu_activity_type;

    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic       wr;
        logic       rd;
    } pmu_bus_type;

endpackage

`default_nettype wire

// ==== logic/pmu_timer.sv ====
// Purpose: one restartable inactivity timer
// Assumes: enable freezes the count
// Notes:   expire is a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none

module pmu_timer #(
    parameter int WIDTH = 32
) (
    input  wire logic             sys_clk_in,
    input  wire logic             rst_in,
    input  wire logic             ce_in,
    input  wire logic             run_in,
    input  wire logic             restart_in,
    input  wire logic [WIDTH-1:0] limit_in,
    output logic                  expire_out
);

    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;
    logic             exp_r;
    logic             exp_nxt;

    // restart on activity; an idle count that reaches the limit fires once
    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (restart_in || !run_in) begin
            cnt_nxt = '0;
        end else if (limit_in != '0 && cnt_r != limit_in) begin
            cnt_nxt = cnt_r + 1'b1;
            exp_nxt = (cnt_r + 1'b1) == limit_in;
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else if (ce_in) begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expire_out = exp_r;

endmodule

`default_nettype wire

// ==== logic/pmu_power_manager.sv ====
// Purpose: power manager: idle timers, power states, stall and plane control
// Assumes: activity and drain-done inputs arrive asynchronously
// Notes:   firmware steers states over the register port
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pmu_regs.svh"

module pmu_power_manager
    import pmu_pkg::*;
#(
    parameter int TW = 32,
    parameter int DRAIN_CYC = `PMU_DRAIN_CYC
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic [3:0]  addr_in,
    input  wire logic [31:0] wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [31:0] rdata_out,
    input  wire logic        sys_act_in,
    input  wire logic        hkeep_act_in,
    input  wire logic        periph_act_in,
    input  wire logic        drain_done_in,
    output logic             system_mgmt_interrupt_out,
    output logic             cpu_stall_modulation_n_out,
    output logic             drain_req_out,
    output logic             clk_stop_out,
    output logic      [7:0]  plane_off_out,
    output logic      [1:0]  pstate_out
);

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
        end else if (ce_in) begin
            s1_r <= {drain_done_in, periph_act_in, hkeep_act_in, sys_act_in};
            s2_r <= s1_r;
        end
    end
    pmu_activity_type act;
    logic             drain_done;
    assign act = '{sys: s2_r[0], hkeep: s2_r[1], periph: s2_r[2]};
    assign drain_done = s2_r[3];

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    pmu_bus_type     bus;
    pmu_pstate_type  st_r, st_nxt;
    logic [TW-1:0]   lim_r   [5];
    logic [TW-1:0]   lim_nxt [5];
    logic [7:0]      stall_r, stall_nxt;
    logic [7:0]      plane_r, plane_nxt;
    logic [5:0]      stat_r, stat_nxt;
    logic [5:0]      mask_r, mask_nxt;
    logic            en_r, en_nxt;
    logic [1:0]      req_r, req_nxt;
    logic [31:0]     rdata_r, rdata_nxt;
    logic            irq_r;
    logic [5:0]      ev;
    assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    logic exp_doze, exp_stby, exp_cpu_stall_modulation, exp_hk, exp_per;
    logic hk_run_r, hk_run_nxt;
    logic run_idle;
    assign run_idle = en_r && st_r != PMU_CPU_STALL_MODULATION;

    pmu_timer #(.WIDTH(TW)) u_doze (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .ce_in (ce_in),
        .run_in (run_idle && st_r == PMU_ON),
        .restart_in (act.sys),
        .limit_in (lim_r[0]), .expire_out (exp_doze));
    pmu_timer #(.WIDTH(TW)) u_stby (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .ce_in (ce_in),
        .run_in (run_idle && st_r != PMU_STBY),
        .restart_in (act.sys),
        .limit_in (lim_r[1]), .expire_out (exp_stby));
    pmu_timer #(.WIDTH(TW)) u_cpu_stall_modulation (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .ce_in (ce_in),
        .run_in (run_idle),
        .restart_in (act.sys),
        .limit_in (lim_r[2]), .expire_out (exp_cpu_stall_modulation));
    pmu_timer #(.WIDTH(TW)) u_hk (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .ce_in (ce_in),
        .run_in (hk_run_r),
        .restart_in (act.hkeep),
        .limit_in (lim_r[3]), .expire_out (exp_hk));
    pmu_timer #(.WIDTH(TW)) u_per (
        .sys_clk_in (sys_clk_in), .rst_in (rst_in), .ce_in (ce_in),
        .run_in (en_r),
        .restart_in (act.periph),
        .limit_in (lim_r[4]), .expire_out (exp_per));

    // house-keeping bursts in doze/standby only arm their own timer
    always_comb begin
        hk_run_nxt = hk_run_r;
        if (st_r != PMU_DOZE && st_r != PMU_STBY) begin
            hk_run_nxt = 1'b0;
        end else if (act.hkeep) begin
            hk_run_nxt = 1'b1;
        end else if (exp_hk) begin
            hk_run_nxt = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // events and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        ev = 6'h00;
        ev[`PMU_EV_DOZE]   = exp_doze;
        ev[`PMU_EV_STBY]   = exp_stby;
        ev[`PMU_EV_CPU_STALL_MODULATION]   = exp_cpu_stall_modulation;
        ev[`PMU_EV_HKEEP]  = exp_hk;
        ev[`PMU_EV_PERIPH] = exp_per;
        ev[`PMU_EV_WAKE]   = act.sys && st_r != PMU_ON;
    end

    // ----------------------------------------------------------------
    // power state machine
    // ----------------------------------------------------------------
    logic [15:0] drain_cnt_r, drain_cnt_nxt;
    logic        dreq_r, dreq_nxt;
    logic        cstop_r, cstop_nxt;

    always_comb begin
        st_nxt = st_r;
        dreq_nxt = dreq_r;
        cstop_nxt = cstop_r;
        drain_cnt_nxt = drain_cnt_r;
        unique case (st_r)
            PMU_ON, PMU_DOZE, PMU_STBY: begin
                cstop_nxt = 1'b0;
                if (req_r == 2'd3) begin
                    // hold off suspend until the core has drained or DRAIN_CYC cycles have passed
                    dreq_nxt = 1'b1;
                    if (drain_done || drain_cnt_r == 16'(DRAIN_CYC)) begin
                        st_nxt = PMU_CPU_STALL_MODULATION;
                        cstop_nxt = 1'b1;
                        dreq_nxt = 1'b0;
                        drain_cnt_nxt = '0;
                    end else begin
                        drain_cnt_nxt = drain_cnt_r + 16'h0001;
                    end
                end else begin
                    st_nxt = pmu_pstate_type'(req_r);
                    dreq_nxt = 1'b0;
                    drain_cnt_nxt = '0;
                end
            end
            PMU_CPU_STALL_MODULATION: begin
                // only clocks stop; all registers keep their contents
                if (req_r != 2'd3) begin
                    st_nxt = pmu_pstate_type'(req_r);
                    cstop_nxt = 1'b0;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // stall modulation: one duty out of 256 for every state
    // ----------------------------------------------------------------
    logic [7:0] pwm_r, pwm_nxt;
    logic       stall_n_r, stall_n_nxt;
    always_comb begin
        pwm_nxt = pwm_r + 8'h01;
        // active low: stall while count under programmed duty
        stall_n_nxt = !(pwm_r < stall_r);
    end

    // ----------------------------------------------------------------
    // register file
    // ----------------------------------------------------------------
    always_comb begin
        lim_nxt = lim_r;
        stall_nxt = stall_r;
        plane_nxt = plane_r;
        mask_nxt = mask_r;
        en_nxt = en_r;
        req_nxt = req_r;
        rdata_nxt = 32'h0000_0000;
        // set wins over write-one-to-clear
        stat_nxt = stat_r;
        if (bus.wr && bus.addr == `PMU_OFF_IRQ_STAT) begin
            stat_nxt = stat_r & ~bus.wdata[5:0];
        end
        stat_nxt = stat_nxt | ev;
        if (bus.wr) begin
            unique case (bus.addr)
                `PMU_OFF_CTRL: begin
                    req_nxt = bus.wdata[`PMU_CTRL_REQ_LSB +: 2];
                    en_nxt  = bus.wdata[`PMU_CTRL_EN_BIT];
                end
                `PMU_OFF_DOZE:     lim_nxt[0] = bus.wdata[TW-1:0];
                `PMU_OFF_STBY:     lim_nxt[1] = bus.wdata[TW-1:0];
                `PMU_OFF_CPU_STALL_MODULATION:     lim_nxt[2] = bus.wdata[TW-1:0];
                `PMU_OFF_HKEEP:    lim_nxt[3] = bus.wdata[TW-1:0];
                `PMU_OFF_PERIPH:   lim_nxt[4] = bus.wdata[TW-1:0];
                `PMU_OFF_STALL:    stall_nxt = bus.wdata[7:0];
                `PMU_OFF_PLANES:   plane_nxt = bus.wdata[7:0];
                `PMU_OFF_IRQ_MASK: mask_nxt = bus.wdata[5:0];
                default: ;
            endcase
        end
        if (bus.rd) begin
            unique case (bus.addr)
                `PMU_OFF_CTRL:     rdata_nxt = {29'h0, en_r, req_r};
                `PMU_OFF_STATE:    rdata_nxt = {29'h0, dreq_r, st_r};
                `PMU_OFF_DOZE:     rdata_nxt = 32'(lim_r[0]);
                `PMU_OFF_STBY:     rdata_nxt = 32'(lim_r[1]);
                `PMU_OFF_CPU_STALL_MODULATION:     rdata_nxt = 32'(lim_r[2]);
                `PMU_OFF_HKEEP:    rdata_nxt = 32'(lim_r[3]);
                `PMU_OFF_PERIPH:   rdata_nxt = 32'(lim_r[4]);
                `PMU_OFF_STALL:    rdata_nxt = {24'h0, stall_r};
                `PMU_OFF_PLANES:   rdata_nxt = {24'h0, plane_r};
                `PMU_OFF_IRQ_STAT: rdata_nxt = {26'h0, stat_r};
                `PMU_OFF_IRQ_MASK: rdata_nxt = {26'h0, mask_r};
                default:           rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            lim_r[0] <= TW'(`PMU_RST_DOZE);
            lim_r[1] <= TW'(`PMU_RST_STBY);
            lim_r[2] <= TW'(`PMU_RST_CPU_STALL_MODULATION);
            lim_r[3] <= TW'(`PMU_RST_HKEEP);
            lim_r[4] <= TW'(`PMU_RST_PERIPH);
            stall_r <= `PMU_RST_STALL;
            plane_r <= `PMU_RST_PLANES;
            mask_r <= `PMU_RST_MASK;
            stat_r <= 6'h00;
            en_r <= 1'b0;
            req_r <= 2'h0;
            rdata_r <= 32'h0000_0000;
            irq_r <= 1'b0;
            st_r <= PMU_ON;
            dreq_r <= 1'b0;
            cstop_r <= 1'b0;
            drain_cnt_r <= 16'h0000;
            hk_run_r <= 1'b0;
            pwm_r <= 8'h00;
            stall_n_r <= 1'b1;
        end else if (ce_in) begin
            lim_r <= lim_nxt;
            stall_r <= stall_nxt;
            plane_r <= plane_nxt;
            mask_r <= mask_nxt;
            stat_r <= stat_nxt;
            en_r <= en_nxt;
            req_r <= req_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= |(stat_nxt & mask_nxt);
            st_r <= st_nxt;
            dreq_r <= dreq_nxt;
            cstop_r <= cstop_nxt;
            drain_cnt_r <= drain_cnt_nxt;
            hk_run_r <= hk_run_nxt;
            pwm_r <= pwm_nxt;
            stall_n_r <= stall_n_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign system_mgmt_interrupt_out = irq_r;
    assign cpu_stall_modulation_n_out = stall_n_r;
    assign drain_req_out = dreq_r;
    assign clk_stop_out = cstop_r;
    assign plane_off_out = plane_r;
    assign pstate_out = st_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_cpu_stall_modulation_req;
        ce_in && req_r == 2'd3 && st_r != PMU_CPU_STALL_MODULATION && !drain_done
            && drain_cnt_r != 16'(DRAIN_CYC);
    endsequence
    property p_drain_first;
        @(posedge sys_clk_in) disable iff (rst_in)
        s_cpu_stall_modulation_req ##1 ce_in |-> dreq_r && st_r != PMU_CPU_STALL_MODULATION;
    endproperty
    a_drain_first: assert property (p_drain_first)
        else $error("suspend entered before drain");
    property p_clk_stop;
        @(posedge sys_clk_in) disable iff (rst_in)
        st_r == PMU_CPU_STALL_MODULATION |-> cstop_r;
    endproperty
    a_clk_stop: assert property (p_clk_stop)
        else $error("clocks running in suspend");
    property p_resume;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && st_r == PMU_CPU_STALL_MODULATION && req_r != 2'd3
            |=> !cstop_r && st_r == pmu_pstate_type'($past(req_r));
    endproperty
    a_resume: assert property (p_resume)
        else $error("resume went to wrong state");
    property p_wake_irq;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && ev[`PMU_EV_WAKE] && mask_r[`PMU_EV_WAKE]
            && !(bus.wr && bus.addr == `PMU_OFF_IRQ_MASK) |=> irq_r;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake event gave no interrupt");
    property p_doze_sticky;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && exp_doze |=> stat_r[`PMU_EV_DOZE];
    endproperty
    a_doze_sticky: assert property (p_doze_sticky)
        else $error("doze expiry not recorded");
    property p_per_sticky;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && exp_per |=> stat_r[`PMU_EV_PERIPH];
    endproperty
    a_per_sticky: assert property (p_per_sticky)
        else $error("peripheral expiry not recorded");
    property p_restart;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && act.sys ##1 ce_in |-> !exp_doze && !exp_cpu_stall_modulation;
    endproperty
    a_restart: assert property (p_restart)
        else $error("timer fired right after activity");
    property p_stall_full;
        @(posedge sys_clk_in) disable iff (rst_in)
        (ce_in && stall_r == 8'h00)[*2] |=> cpu_stall_modulation_n_out;
    endproperty
    a_stall_full: assert property (p_stall_full)
        else $error("stall asserted at zero duty");
    property p_planes;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && bus.wr && bus.addr == `PMU_OFF_PLANES
            |=> {24'h0, plane_off_out} == ($past(wdata_in) & 32'h0000_00FF);
    endproperty
    a_planes: assert property (p_planes)
        else $error("plane control not updated");
    property p_hk_state;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && hk_run_r && exp_hk |-> st_r == PMU_DOZE || st_r == PMU_STBY
            || $past(st_r) != st_r;
    endproperty
    a_hk_state: assert property (p_hk_state)
        else $error("house-keeping timer outside doze or standby");
    property p_states;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && req_r == 2'd1 && st_r != PMU_CPU_STALL_MODULATION |=> st_r == PMU_DOZE;
    endproperty
    a_states: assert property (p_states)
        else $error("doze request not honoured");
    property p_timers;
        @(posedge sys_clk_in) disable iff (rst_in)
        ce_in && !en_r |=> !exp_cpu_stall_modulation;
    endproperty
    a_timers: assert property (p_timers)
        else $error("suspend timer ran while disabled");

endmodule

`default_nettype wire

// ==== tb/pmu_core_model.sv ====
// Purpose: processor core stand-in for the suspend handshake
// Assumes: drain delay set by the bench, 8'hFF never answers
// Notes:   step count shows whether the core is running
`timescale 1ns/1ps
`default_nettype none

module pmu_core_model (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        drain_req_in,
    input  wire logic        clk_stop_in,
    input  wire logic [7:0]  delay_in,
    output logic             drain_done_out,
    output logic      [15:0] step_out
);
    // ----------------------------------------------------------------
    // drain and step
    // ----------------------------------------------------------------
    logic [7:0] cnt_r;

    // done only once pending work is finished
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_r <= 8'h00;
            drain_done_out <= 1'b0;
        end else if (!drain_req_in) begin
            cnt_r <= 8'h00;
            drain_done_out <= 1'b0;
        end else if (delay_in != 8'hFF && cnt_r >= delay_in) begin
            drain_done_out <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    // frozen while clocks stop, resumes from the same count
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in)
            step_out <= 16'h0000;
        else if (!clk_stop_in && !drain_done_out)
            step_out <= step_out + 16'h0001;
    end
endmodule

`default_nettype wire

// ==== tb/power_management_unit_tb.sv ====
// Purpose: self-checking bench for the power manager
// Assumes: register port timing as handed over, drain time-out of 16
// Notes:   small timer limits keep the run short
`timescale 1ns/1ps
`default_nettype none
`include "pmu_regs.svh"

module power_management_unit_tb;
    import pmu_pkg::*;
    logic        sys_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        ce_in = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        sact = 1'b0;
    logic        hact = 1'b0;
    logic        pact = 1'b0;
    logic [7:0]  delay = 8'h0A;
    logic [31:0] rdata;
    logic        irq, stall_n, dreq, cstop, done;
    logic [7:0]  planes;
    logic [1:0]  pstate;
    logic [15:0] step;
    logic [31:0] rst_tbl [16];
    int          failures = 0;
    int          compares = 0;

    always #5 sys_clk_in = ~sys_clk_in;

    pmu_power_manager #(.TW(32), .DRAIN_CYC(16)) DUT (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .ce_in(ce_in),
        .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdata), .sys_act_in(sact), .hkeep_act_in(hact),
        .periph_act_in(pact), .drain_done_in(done),
        .system_mgmt_interrupt_out(irq),
        .cpu_stall_modulation_n_out(stall_n),
        .drain_req_out(dreq), .clk_stop_out(cstop),
        .plane_off_out(planes), .pstate_out(pstate));

    pmu_core_model core (
        .sys_clk_in(sys_clk_in), .rst_in(rst_in), .drain_req_in(dreq),
        .clk_stop_in(cstop), .delay_in(delay), .drain_done_out(done),
        .step_out(step));

    // ----------------------------------------------------------------
    // bus and check tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("failures=%0d compares=%0d", failures, compares);
        if (failures == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t reg %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t pin %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
        @(posedge sys_clk_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic wait_hi(input bit on_stop, input int lim, output int n);
        n = 0;
        while ((on_stop ? cstop : irq) !== 1'b1) begin
            tick(1);
            n++;
            if (n > lim) begin
                failures++;
                $display("mismatch t=%0t wait expired", $time);
                conclude();
            end
        end
    endtask

    initial begin
        #900000;
        failures++;
        $display("mismatch t=%0t run too long", $time);
        conclude();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] v;
        int n;
        rst_tbl = '{default: 32'h0};
        rst_tbl[2] = `PMU_RST_DOZE;
        rst_tbl[3] = `PMU_RST_STBY;
        rst_tbl[4] = `PMU_RST_CPU_STALL_MODULATION;
        rst_tbl[5] = `PMU_RST_HKEEP;
        rst_tbl[6] = `PMU_RST_PERIPH;
        rst_tbl[8] = 32'h0000_00FF;
        repeat (4) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        tick(1);
        chk_pin({8'h00, planes}, 16'h00FF);
        chk_pin({13'h0, stall_n, pstate}, 16'h0004);
        for (int i = 1; i < 16; i++) begin
            rd_reg(i[3:0], v);
            chk_reg(v, rst_tbl[i]);
        end
        wr_reg(4'hA, 32'h0000_003F);
        // the doze, standby and suspend timers each alone raise their own status bit
        for (int i = 0; i < 3; i++) begin
            for (int j = 2; j < 7; j++)
                wr_reg(j[3:0], (j == i + 2) ? 32'h14 : 32'h0);
            wr_reg(4'h9, 32'h3F);
            wr_reg(4'h0, 32'h4);
            wait_hi(0, 100, n);
            chk_pin(16'(n >= 16), 16'h1);
            rd_reg(4'h9, v);
            chk_reg(v, 32'h1 << i);
            wr_reg(4'h0, 32'h0);
            wr_reg(4'h9, 32'h3F);
            tick(1);
            chk_pin({15'h0, irq}, 16'h0);
        end
        // activity bursts keep the doze timer from expiring
        for (int j = 3; j < 5; j++)
            wr_reg(j[3:0], 32'h0);
        wr_reg(4'h2, 32'h14);
        wr_reg(4'h0, 32'h4);
        repeat (10) begin
            sact <= 1'b1;
            tick(2);
            sact <= 1'b0;
            tick(8);
            chk_pin({15'h0, irq}, 16'h0);
        end
        wait_hi(0, 100, n);
        chk_pin(16'(n), 16'd15);
        wr_reg(4'h2, 32'h0);
        for (int s = 1; s < 3; s++) begin
            wr_reg(4'h0, 32'(s));
            tick(1);
            chk_pin({14'h0, pstate}, 16'(s));
        end
        // house-keeping burst in standby keeps the state
        wr_reg(4'h5, 32'hA);
        wr_reg(4'h0, 32'h6);
        wr_reg(4'h9, 32'h3F);
        hact <= 1'b1;
        tick(2);
        hact <= 1'b0;
        wait_hi(0, 60, n);
        rd_reg(4'h9, v);
        chk_reg(v, 32'h8);
        chk_pin({14'h0, pstate}, 16'h2);
        wr_reg(4'h5, 32'h0);
        wr_reg(4'h9, 32'h3F);
        sact <= 1'b1;
        tick(2);
        sact <= 1'b0;
        tick(4);
        rd_reg(4'h9, v);
        chk_reg(v & 32'h20, 32'h20);
        chk_pin({15'h0, irq}, 16'h1);
        wr_reg(4'h0, 32'h4);
        wr_reg(4'h6, 32'h14);
        wr_reg(4'h9, 32'h3F);
        wait_hi(0, 100, n);
        rd_reg(4'h9, v);
        chk_reg(v & 32'h10, 32'h10);
        wr_reg(4'h6, 32'h0);
        wr_reg(4'h9, 32'h3F);
        // stall duty checked in on, doze and standby, 256-cycle period
        for (int s = 0; s < 3; s++) begin
            wr_reg(4'h0, 32'(s));
            wr_reg(4'h7, 32'(64 * (s + 1)));
            tick(2);
            n = 0;
            repeat (256) begin
                n += (stall_n === 1'b0);
                tick(1);
            end
            chk_pin(16'(n), 16'(64 * (s + 1)));
        end
        wr_reg(4'h7, 32'h0);
        wr_reg(4'h8, 32'h5A);
        tick(1);
        chk_pin({8'h00, planes}, 16'h005A);
        ce_in <= 1'b0;
        wr_reg(4'h8, 32'h00);
        ce_in <= 1'b1;
        tick(1);
        chk_pin({8'h00, planes}, 16'h005A);
        // suspend by handshake, then by time-out
        wr_reg(4'h0, 32'h3);
        tick(1);
        chk_pin({15'h0, dreq}, 16'h1);
        wait_hi(1, 40, n);
        chk_pin(16'(n >= 9), 16'h1);
        chk_pin({14'h0, pstate}, 16'h3);
        v = {16'h0, step};
        tick(20);
        chk_pin(step, v[15:0]);
        wr_reg(4'h0, 32'h0);
        tick(1);
        chk_pin({13'h0, cstop, pstate}, 16'h0);
        tick(5);
        chk_pin(16'(step > v[15:0]), 16'h1);
        rd_reg(4'h8, v);
        chk_reg(v, 32'h5A);
        delay <= 8'hFF;
        wr_reg(4'h0, 32'h3);
        wait_hi(1, 30, n);
        chk_pin(16'(n), 16'd17);
        chk_pin({14'h0, pstate}, 16'h3);
        wr_reg(4'h0, 32'h0);
        tick(1);
        chk_pin({14'h0, pstate}, 16'h0);
        conclude();
    end
endmodule

`default_nettype wire
